// *** pin_load_model.sv ***
/*
 * external load on the compare output pin: resolves the wire level and
 * counts high cycles inside a measuring window.
 * assumes a pull-down on the wire whenever the timer does not drive it.
 */
`timescale 1ns/100ps
module pin_load_model (
    // clock and window control
    input wire logic clk_sys_in,
    input wire logic window_clear_in,
    // pin from the timer
    input wire logic pin_in,
    input wire logic pin_oe_in,
    // observed wire
    output logic pin_level_out,
    output logic [15:0] high_count_out
);
    ////////////////////////////////////////////////////////////////////
    // pull-down takes the wire while the driver is off
    assign pin_level_out = pin_oe_in ? pin_in : 1'b0;
    // high cycle counter, restarted by the window clear
    always_ff @(posedge clk_sys_in) begin
        if (window_clear_in) begin
            high_count_out <= 16'h0000;
        end else if (pin_level_out) begin
            high_count_out <= high_count_out + 16'h0001;
        end
    end
endmodule // pin_load_model

// *** test_timer8_compare_waveform_gen.sv ***
/*
 * self-checking bench for the 8-bit compare waveform timer.
 * assumes the register map of the shared package and a pin load model.
 */
`timescale 1ns/100ps
module test_timer8_compare_waveform_gen;
    import timer8_wave_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic pin, pin_oe, ovf, mflag, level, window_clear = 1'b0;
    logic [15:0] high_count;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////
    always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    timer8_compare_waveform_gen i_dut (.clk_sys_in(clk_sys), .rst_in(rst),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_write_in(reg_write), .reg_read_in(reg_read),
        .reg_rdata_out(reg_rdata), .pin_out(pin), .pin_oe_out(pin_oe),
        .overflow_flag_out(ovf), .compare_match_flag_out(mflag));
    pin_load_model i_load (.clk_sys_in(clk_sys),
        .window_clear_in(window_clear), .pin_in(pin), .pin_oe_in(pin_oe),
        .pin_level_out(level), .high_count_out(high_count));
    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    // read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        check({8'h00, reg_rdata}, {8'h00, e});
    endtask
    // control byte: force, clock select, action, mode
    function automatic logic [7:0] ctl(input logic [1:0] m,
        input logic [1:0] a, input logic [2:0] c, input logic f);
        return {f, c, a, m};
    endfunction
    // run for k+2 system clock cycles at clock select c, then stop
    task automatic run(input logic [1:0] m, input logic [1:0] a,
        input logic [2:0] c, input int k);
        wr(ADDR_CTRL, ctl(m, a, c, 1'b0));
        repeat (k) @(posedge clk_sys);
        wr(ADDR_CTRL, ctl(m, a, CLKSEL_STOP, 1'b0));
    endtask
    ////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 15000) begin
            mismatches++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////
    logic [1:0] pw_act [5] = '{ACT_CLEAR, ACT_SET, ACT_TOGGLE, ACT_CLEAR,
        ACT_SET};
    logic [7:0] pw_cmp [5] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'hFF};
    logic [15:0] pw_high [5] = '{16'h0082, 16'h017E, 16'h0100, 16'h0002,
        16'h0200};
    int pre_div [7] = '{1, 8, 32, 64, 128, 256, 1024};
    initial begin
        logic [15:0] seen;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check({pin, pin_oe}, 16'h0000);
        rd(ADDR_CTRL, 8'h00);
        // preset the compare state while the pin is not driven
        wr(ADDR_CTRL, ctl(MODE_NORMAL, ACT_SET, CLKSEL_STOP, 1'b1));
        @(negedge clk_sys);
        check({pin, level}, 16'h0002);
        rd(ADDR_FLAGS, 8'h00);
        rd(ADDR_COUNT, 8'h00);
        wr(ADDR_PORT, 8'h02);
        @(negedge clk_sys);
        check(level, 16'h0001);
        wr(ADDR_CTRL, ctl(MODE_CLEAR_ON_MATCH, ACT_CLEAR, CLKSEL_STOP, 1'b1));
        @(negedge clk_sys);
        check(level, 16'h0000);
        wr(ADDR_CTRL, ctl(MODE_NORMAL, ACT_TOGGLE, CLKSEL_STOP, 1'b1));
        @(negedge clk_sys);
        check(level, 16'h0001);
        wr(ADDR_CTRL, ctl(MODE_NORMAL, ACT_NONE, CLKSEL_STOP, 1'b1));
        @(negedge clk_sys);
        check(level, 16'h0000);
        wr(ADDR_CTRL, ctl(MODE_NORMAL, ACT_TOGGLE, CLKSEL_STOP, 1'b0));
        @(negedge clk_sys);
        check(level, 16'h0001);
        // normal mode wrap, compare 0 matched after the wrap
        wr(ADDR_COUNT, 8'hFD);
        run(MODE_NORMAL, ACT_NONE, 3'h1, 3);
        rd(ADDR_COUNT, 8'h02);
        rd(ADDR_FLAGS, 8'h03);
        check({mflag, ovf}, 16'h0003);
        wr(ADDR_FLAGS, 8'h03);
        rd(ADDR_FLAGS, 8'h00);
        check({mflag, ovf}, 16'h0000);
        // count write equal to compare suppresses the first match
        wr(ADDR_COMPARE, 8'h10);
        wr(ADDR_COUNT, 8'h10);
        run(MODE_NORMAL, ACT_NONE, 3'h1, 2);
        rd(ADDR_COUNT, 8'h14);
        rd(ADDR_FLAGS, 8'h00);
        // clear-on-match with toggle, top 3
        wr(ADDR_COMPARE, 8'h03);
        wr(ADDR_COUNT, 8'h00);
        run(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, 3'h1, 4);
        rd(ADDR_COUNT, 8'h02);
        check(level, 16'h0000);
        rd(ADDR_FLAGS, 8'h02);
        check({mflag, ovf}, 16'h0002);
        // compare below count: runs through the wrap first
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_COUNT, 8'h10);
        run(MODE_CLEAR_ON_MATCH, ACT_NONE, 3'h1, 240);
        rd(ADDR_COUNT, 8'h02);
        rd(ADDR_FLAGS, 8'h01);
        // every prescale factor gives two ticks in two periods
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_COUNT, 8'h00);
            run(MODE_NORMAL, ACT_NONE, 3'(i + 1), 2 * pre_div[i] - 2);
            rd(ADDR_COUNT, 8'h02);
        end
        // fast pwm duty over two full periods
        wr(ADDR_FLAGS, 8'h03);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_COMPARE, pw_cmp[i]);
            wr(ADDR_CTRL, ctl(MODE_FAST_PWM, pw_act[i], 3'h1, 1'b0));
            // buffered compare needs up to two periods to show
            repeat (600) @(posedge clk_sys);
            window_clear <= 1'b1;
            @(posedge clk_sys);
            window_clear <= 1'b0;
            repeat (512) @(posedge clk_sys);
            @(negedge clk_sys);
            seen = high_count;
            check(seen, pw_high[i]);
        end
        wr(ADDR_CTRL, ctl(MODE_FAST_PWM, ACT_NONE, CLKSEL_STOP, 1'b0));
        rd(ADDR_FLAGS, 8'h03);
        test_done();
    end
endmodule // test_timer8_compare_waveform_gen

// *** timer8_compare_waveform_gen.sv ***
/*
 * 8-bit timer with compare match output unit: normal, clear-on-match
 * and fast single-slope pwm counting, force strobe, flags, port override.
 * assumes one 10 MHz clock, an 8-bit register port with read data one
 * cycle after the read strobe, and an external load on the output pin.
 */
`timescale 1ns/100ps
module timer8_compare_waveform_gen
    import timer8_wave_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // compare output pin
    output logic pin_out,
    output logic pin_oe_out,
    // status
    output logic overflow_flag_out,
    output logic compare_match_flag_out
);

    ////////////////////////////////////////////////////////////////////
    // state
    logic [1:0] waveform_mode_select_r; // counting mode
    logic [1:0] compare_output_action_r; // output action
    logic [2:0] clock_select_field_r; // prescale choice
    logic [7:0] counter_value_r; // live count
    logic [7:0] compare_value_r; // active comparator value
    logic [7:0] compare_buf_r; // software-side buffer
    logic overflow_flag_r; // sticky overflow
    logic compare_match_flag_r; // sticky match
    logic compare_output_state_r; // internal output state
    logic port_data_r; // general port data
    logic output_pin_direction_r; // pin direction
    logic match_block_r; // blocks next match after count write
    logic [PRE_W-1:0] pre_r; // free-running prescaler
    logic [7:0] rdata_r; // read data register

    ////////////////////////////////////////////////////////////////////
    // decode
    logic wr_ctrl, wr_count, wr_compare, wr_flags, wr_port;
    logic is_pwm, tick, raw_match, match, force_now;
    logic [PRE_W-1:0] pre_mask;
    logic [1:0] act_field;

    // write strobes per register
    assign wr_ctrl = reg_write_in && (reg_addr_in == ADDR_CTRL);
    assign wr_count = reg_write_in && (reg_addr_in == ADDR_COUNT);
    assign wr_compare = reg_write_in && (reg_addr_in == ADDR_COMPARE);
    assign wr_flags = reg_write_in && (reg_addr_in == ADDR_FLAGS);
    assign wr_port = reg_write_in && (reg_addr_in == ADDR_PORT);
    assign is_pwm = (waveform_mode_select_r == MODE_FAST_PWM);
    assign act_field = reg_wdata_in[CTRL_ACTION_LSB +: 2];
    // force uses the action written in the same write
    assign force_now = wr_ctrl && reg_wdata_in[CTRL_FORCE_BIT] &&
        (reg_wdata_in[CTRL_MODE_LSB +: 2] != MODE_FAST_PWM);

    ////////////////////////////////////////////////////////////////////
    // prescaler: tick when the selected low bits are all ones
    always_comb begin
        case (clock_select_field_r)
            3'h1: pre_mask = PRE_MASK_1;
            3'h2: pre_mask = PRE_MASK_8;
            3'h3: pre_mask = PRE_MASK_32;
            3'h4: pre_mask = PRE_MASK_64;
            3'h5: pre_mask = PRE_MASK_128;
            3'h6: pre_mask = PRE_MASK_256;
            3'h7: pre_mask = PRE_MASK_1024;
            default: pre_mask = PRE_MASK_1;
        endcase
    end
    // stopped when clock select is zero
    assign tick = (clock_select_field_r != CLKSEL_STOP) &&
        ((pre_r & pre_mask) == pre_mask);

    // free-running divider
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PRE_ONE;
        end
    end

    // comparator, gated by a recent count write
    assign raw_match = (counter_value_r == compare_value_r);
    assign match = tick && raw_match && !match_block_r;

    ////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            waveform_mode_select_r <= MODE_NORMAL;
            compare_output_action_r <= ACT_NONE;
            clock_select_field_r <= CLKSEL_STOP;
        end else if (wr_ctrl) begin
            // action takes effect at the next match, no buffering
            waveform_mode_select_r <= reg_wdata_in[CTRL_MODE_LSB +: 2];
            compare_output_action_r <= act_field;
            clock_select_field_r <= reg_wdata_in[CTRL_CLKSEL_LSB +: 3];
        end
    end

    // port data and direction
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            port_data_r <= 1'b0;
            output_pin_direction_r <= 1'b0;
        end else if (wr_port) begin
            port_data_r <= reg_wdata_in[PORT_DATA_BIT];
            output_pin_direction_r <= reg_wdata_in[PORT_DIR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter: software write has priority over counting
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            counter_value_r <= COUNT_BOTTOM;
        end else if (wr_count) begin
            counter_value_r <= reg_wdata_in;
        end else if (tick) begin
            // sequence depends on mode only; compare is top in ctc
            if (waveform_mode_select_r == MODE_CLEAR_ON_MATCH && match) begin
                counter_value_r <= COUNT_BOTTOM;
            end else begin
                // normal, phase, fast pwm and a missed top run on via ff
                counter_value_r <= counter_value_r + COUNT_ONE;
            end
        end
    end

    // match blocking after a count write, held until next tick
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            match_block_r <= 1'b0;
        end else if (wr_count) begin
            match_block_r <= 1'b1;
        end else if (tick) begin
            match_block_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare value: direct in non-pwm, buffered to top in pwm
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            compare_buf_r <= REG_ZERO;
        end else if (wr_compare) begin
            compare_buf_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            compare_value_r <= REG_ZERO;
        end else if (wr_compare && !is_pwm) begin
            compare_value_r <= reg_wdata_in;
        end else if (!is_pwm || (tick && counter_value_r == COUNT_MAX)) begin
            // pwm loads only at top; non-pwm follows the buffer
            compare_value_r <= compare_buf_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over software write-one clear
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            overflow_flag_r <= 1'b0;
        end else if (tick && counter_value_r == COUNT_MAX && !wr_count) begin
            // all modes: set on the max-to-zero step, pwm at max
            overflow_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata_in[FLAG_OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            compare_match_flag_r <= 1'b0;
        end else if (match) begin
            // force never reaches here
            compare_match_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata_in[FLAG_MATCH_BIT]) begin
            compare_match_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // waveform generator on the internal compare state
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            compare_output_state_r <= 1'b0;
        end else if (force_now) begin
            // set-up path before the pin is enabled
            case (act_field)
                ACT_TOGGLE: compare_output_state_r <= !compare_output_state_r;
                ACT_CLEAR: compare_output_state_r <= 1'b0;
                ACT_SET: compare_output_state_r <= 1'b1;
                default: compare_output_state_r <= compare_output_state_r;
            endcase
        end else if (is_pwm && tick) begin
            // match beats bottom, giving constant level at max for clear and set
            if (match) begin
                case (compare_output_action_r)
                    ACT_TOGGLE: compare_output_state_r <=
                        !compare_output_state_r;
                    ACT_CLEAR: compare_output_state_r <= 1'b0;
                    ACT_SET: compare_output_state_r <= 1'b1;
                    default: compare_output_state_r <=
                        compare_output_state_r;
                endcase
            end else if (counter_value_r == COUNT_MAX) begin
                case (compare_output_action_r)
                    ACT_CLEAR: compare_output_state_r <= 1'b1;
                    ACT_SET: compare_output_state_r <= 1'b0;
                    default: compare_output_state_r <= compare_output_state_r;
                endcase
            end
        end else if (match) begin
            case (compare_output_action_r)
                ACT_TOGGLE: compare_output_state_r <= !compare_output_state_r;
                ACT_CLEAR: compare_output_state_r <= 1'b0;
                ACT_SET: compare_output_state_r <= 1'b1;
                default: compare_output_state_r <= compare_output_state_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin: override set by action only, direction by port bit
    assign pin_out = (compare_output_action_r != ACT_NONE) ?
        compare_output_state_r : port_data_r;
    assign pin_oe_out = output_pin_direction_r;
    assign overflow_flag_out = overflow_flag_r;
    assign compare_match_flag_out = compare_match_flag_r;

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= REG_ZERO;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                ADDR_CTRL: rdata_r <= {1'b0, clock_select_field_r,
                    compare_output_action_r, waveform_mode_select_r};
                ADDR_COUNT: rdata_r <= counter_value_r;
                ADDR_COMPARE: rdata_r <= compare_buf_r;
                ADDR_FLAGS: rdata_r <= {6'h00, compare_match_flag_r,
                    overflow_flag_r};
                ADDR_PORT: rdata_r <= {6'h00, output_pin_direction_r,
                    port_data_r};
                default: rdata_r <= REG_ZERO;
            endcase
        end else begin
            rdata_r <= REG_ZERO;
        end
    end
    assign reg_rdata_out = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_override;
        @(posedge clk_sys_in) disable iff (rst_in)
        (compare_output_action_r != ACT_NONE) |->
            pin_out == compare_output_state_r;
    endproperty
    a_override: assert property (p_override)
        else $error("pin not driven from compare state");

    property p_direction;
        @(posedge clk_sys_in) disable iff (rst_in)
        wr_port |=> pin_oe_out == $past(reg_wdata_in[PORT_DIR_BIT]);
    endproperty
    a_direction: assert property (p_direction)
        else $error("pin enable not following direction bit");

    property p_normal_wrap;
        @(posedge clk_sys_in) disable iff (rst_in)
        (tick && !wr_count && !wr_ctrl &&
            waveform_mode_select_r == MODE_NORMAL &&
            counter_value_r == COUNT_MAX) |=>
            counter_value_r == COUNT_BOTTOM && overflow_flag_r;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap)
        else $error("normal mode wrap or overflow wrong");

    property p_ctc_clear;
        @(posedge clk_sys_in) disable iff (rst_in)
        (match && !wr_count &&
            waveform_mode_select_r == MODE_CLEAR_ON_MATCH) |=>
            counter_value_r == COUNT_BOTTOM;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear)
        else $error("counter not cleared on match");

    property p_toggle;
        @(posedge clk_sys_in) disable iff (rst_in)
        (match && !force_now && !is_pwm &&
            compare_output_action_r == ACT_TOGGLE) |=>
            compare_output_state_r != $past(compare_output_state_r);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("compare state did not toggle");

    property p_block;
        @(posedge clk_sys_in) disable iff (rst_in)
        (tick && match_block_r && raw_match && !compare_match_flag_r) |=>
            !compare_match_flag_r;
    endproperty
    a_block: assert property (p_block)
        else $error("match after counter write not blocked");

    property p_stop;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clock_select_field_r == CLKSEL_STOP && !wr_count) |=>
            $stable(counter_value_r);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter moved while stopped");

    property p_force_flag;
        @(posedge clk_sys_in) disable iff (rst_in)
        (force_now && !match && !compare_match_flag_r) |=>
            !compare_match_flag_r;
    endproperty
    a_force_flag: assert property (p_force_flag)
        else $error("force set the match flag");

    property p_idle_action;
        @(posedge clk_sys_in) disable iff (rst_in)
        (match && !force_now && compare_output_action_r == ACT_NONE) |=>
            $stable(compare_output_state_r);
    endproperty
    a_idle_action: assert property (p_idle_action)
        else $error("compare state changed with no action");

endmodule // timer8_compare_waveform_gen

// *** timer8_wave_pkg.sv ***
/*
 * constants shared by the 8-bit compare waveform timer: register offsets,
 * field positions, reset values, mode codes and prescale masks.
 * assumes an 8-bit register port and one 10 MHz system clock.
 */
package timer8_wave_pkg;
    // system clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    // register offsets on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_COUNT = 3'h1;
    localparam logic [2:0] ADDR_COMPARE = 3'h2;
    localparam logic [2:0] ADDR_FLAGS = 3'h3;
    localparam logic [2:0] ADDR_PORT = 3'h4;
    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTION_LSB = 2;
    localparam int CTRL_CLKSEL_LSB = 4;
    localparam int CTRL_FORCE_BIT = 7;
    // flag and port bit positions
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_MATCH_BIT = 1;
    localparam int PORT_DATA_BIT = 0;
    localparam int PORT_DIR_BIT = 1;
    // reset and extreme values
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] REG_ZERO = 8'h00;
    // waveform mode codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PHASE = 2'h1;
    localparam logic [1:0] MODE_CLEAR_ON_MATCH = 2'h2;
    localparam logic [1:0] MODE_FAST_PWM = 2'h3;
    // compare output action codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // clock select codes
    localparam logic [2:0] CLKSEL_STOP = 3'h0;
    // prescaler width and tick masks for 1,8,32,64,128,256,1024
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_MASK_1 = 10'h000;
    localparam logic [PRE_W-1:0] PRE_MASK_8 = 10'h007;
    localparam logic [PRE_W-1:0] PRE_MASK_32 = 10'h01F;
    localparam logic [PRE_W-1:0] PRE_MASK_64 = 10'h03F;
    localparam logic [PRE_W-1:0] PRE_MASK_128 = 10'h07F;
    localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0FF;
    localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;
    localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
endpackage
